// *** bench/datapath_model.sv ***
/*
 * behavioural fifo datapath on the far side of the control block.
 * assumes the same clock; fills on pushReq, drains on host reads.
 */
module datapath_model (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         pushReq,
   input  wire logic         rxFifoReset,
   input  wire logic         txFifoReset,
   input  wire logic         rxDataRead,
   input  wire logic         txDataWrite,
   output uart_ctrl_pkg::rx_side_t rxSide,
   output logic              txFifoEmpty,
   output logic              txFifoFull,
   output logic              bitTick
);
   timeunit 1ns;
   timeprecision 1ns;
   import uart_ctrl_pkg::*;
   logic [4:0] fill_r;  // rx characters held
   logic [4:0] txCnt_r; // tx characters, never drained
   logic [1:0] tick_r;  // short bit time keeps runs short
   // ========================================================
   // fifo levels; a reset wins over a same-cycle transfer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fill_r  <= 5'h00;
         txCnt_r <= 5'h00;
      end else begin
         if (rxFifoReset) fill_r <= 5'h00;
         else fill_r <= fill_r + 5'(pushReq) - 5'(rxDataRead && fill_r != 0);
         if (txFifoReset) txCnt_r <= 5'h00;
         else if (txDataWrite && !txFifoFull) txCnt_r <= txCnt_r + 5'h01;
      end
   end
   // ========================================================
   // bit time divider
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) tick_r <= 2'h0;
      else tick_r <= tick_r + 2'h1;
   end
   assign bitTick     = (tick_r == 2'h3);
   assign rxSide      = '{fill: fill_r, push: pushReq};
   assign txFifoEmpty = (txCnt_r == 5'h00);
   assign txFifoFull  = (txCnt_r == 5'h10);
endmodule

// *** bench/testbench.sv ***
/*
 * self-checking bench for the uart control block.
 * assumes the datapath model and the bound checker.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import uart_ctrl_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0;
   logic pushReq = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wrData = 8'h00, rv, rdData;
   logic [3:0] lineErr = 4'h0, modemDelta = 4'h0;
   rx_side_t rxSide;
   fifo_cfg_t fifoCfg;
   line_cfg_t lineCfg;
   logic txFifoEmpty, txFifoFull, bitTick, rxFifoReset, txFifoReset;
   logic rxDataRead, txDataWrite, lineStatusRead, intr;
   logic modemStatusRead, receiveReadyPinN, transmitReadyPinN;
   int n_fail = 0, samples_checked = 0;
   always #25 clk = ~clk;
   uart_intr_fifo_line_ctrl dut (.*);
   datapath_model u_dp (.*);
   // ========================================================
   // bus cycles and comparison
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      @(negedge clk);
      rv = rdData;
   endtask
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic src(input logic [7:0] e);
      rd(3'h2);
      chk(e, rv);
   endtask
   task automatic push;
      @(posedge clk);
      pushReq <= 1'b1;
      @(posedge clk);
      pushReq <= 1'b0;
   endtask
   task automatic final_report;
      $display("checked %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ========================================================
   // scenarios
   task automatic t_reset_regs;
      src(8'h01);
      rd(3'h7);
      chk(8'h00, rv);
      for (int w = 0; w < 32; w += 5) begin
         wr(3'h3, 8'(w));
         rd(3'h3);
         chk(8'(w), rv);
      end
      $display("test reset_regs done");
   endtask
   task automatic t_fifo_cfg;
      for (int t = 0; t < 4; t++) begin
         wr(3'h2, {2'(t), 2'b00, 1'(t), 3'b001});
         @(negedge clk);
         chk({4'h0, 2'(t), 1'(t), 1'b1}, 8'(fifoCfg));
         src(8'hC1);
      end
      wr(3'h2, 8'h06);
      src(8'h01);
      $display("test fifo_cfg done");
   endtask
   task automatic t_priority;
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h01);
      push();
      @(posedge clk);
      lineErr <= 4'h1;
      modemDelta <= 4'h1;
      src(8'hC1);
      wr(3'h1, 8'h0F);
      @(negedge clk);
      chk(8'h01, {7'h0, intr});
      src(8'hC6);
      rd(3'h5);
      src(8'hC4);
      rd(3'h0);
      src(8'hC2);
      src(8'hC0);
      rd(3'h6);
      src(8'hC1);
      chk(8'h00, {7'h0, intr});
      @(posedge clk);
      lineErr <= 4'h0;
      modemDelta <= 4'h0;
      $display("test priority done");
   endtask
   task automatic t_timeout;
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h41);
      push();
      repeat (30) @(posedge bitTick);
      src(8'hC1);
      repeat (10) @(posedge bitTick);
      src(8'hCC);
      rd(3'h0);
      src(8'hC1);
      $display("test timeout done");
   endtask
   task automatic t_fifo_reset;
      wr(3'h0, 8'h55);
      push();
      @(negedge clk);
      chk(8'h02, {6'h0, transmitReadyPinN, receiveReadyPinN});
      wr(3'h2, 8'h07);
      repeat (2) @(posedge clk);
      src(8'hC2);
      wr(3'h0, 8'hAA);
      src(8'hC1);
      $display("test fifo_reset done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset_regs();
      t_fifo_cfg();
      t_priority();
      t_timeout();
      t_fifo_reset();
      final_report();
   end
   initial begin
      #(50 * 5000);
      n_fail++;
      final_report();
   end
endmodule

// *** bench/uart_ctrl_assertions.sv ***
/*
 * port-level checker for the uart control block.
 * assumes one clock and one-cycle read answers.
 */
module uart_ctrl_assertions (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic [2:0]              addr,
   input  wire logic [7:0]              wrData,
   input  wire logic                    wrStrobe,
   input  wire logic                    rdStrobe,
   input  wire logic [7:0]              rdData,
   input  wire logic                    rxFifoReset,
   input  wire logic                    txFifoReset,
   input  wire logic                    rxDataRead,
   input  wire logic                    lineStatusRead,
   input  wire uart_ctrl_pkg::fifo_cfg_t fifoCfg,
   input  wire uart_ctrl_pkg::line_cfg_t lineCfg,
   input  wire logic                    intr
);
   import uart_ctrl_pkg::*;
   // ========================================================
   // helpers: write data and interrupt level one cycle back
   logic [7:0] wrQ_r;   // data of the last cycle
   logic       intrQ_r; // interrupt level of the last cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrQ_r   <= 8'h00;
         intrQ_r <= 1'b0;
      end else begin
         wrQ_r   <= wrData;
         intrQ_r <= intr;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ========================================================
   // steps of the fifo control and source register accesses
   sequence s_fifoWr;
      wrStrobe && addr == 3'h2 && wrData[0];
   endsequence
   sequence s_srcRd;
      rdStrobe && addr == 3'h2;
   endsequence
   a_rx_reset: assert property (s_fifoWr ##0 wrData[1] |=> rxFifoReset)
      else $error("rx fifo reset pulse missing");
   a_tx_reset: assert property (s_fifoWr ##0 wrData[2] |=> txFifoReset)
      else $error("tx fifo reset pulse missing");
   a_gate_write: assert property (wrStrobe && addr == 3'h2 && !wrData[0]
      |=> !rxFifoReset && !txFifoReset && !fifoCfg.enable)
      else $error("fifo control write without enable acted");
   a_fifo_cfg: assert property (s_fifoWr
      |=> fifoCfg == {wrQ_r[7:6], wrQ_r[3], 1'b1})
      else $error("fifo configuration not taken");
   a_line_fmt: assert property (wrStrobe && addr == 3'h3
      |=> lineCfg == {wrQ_r[1:0], wrQ_r[2], wrQ_r[3], wrQ_r[4]})
      else $error("line format not taken");
   a_src_upper: assert property (s_srcRd |=> rdData[5:4] == 2'b00
      && rdData[7:6] == {2{fifoCfg.enable}})
      else $error("source upper bits wrong");
   a_pend_bit: assert property (s_srcRd |=> rdData[0] == !intrQ_r)
      else $error("pending bit disagrees with interrupt");
   a_code_legal: assert property (s_srcRd
      |=> rdData[3:0] inside {4'h6, 4'hC, 4'h4, 4'h2, 4'h0, 4'h1})
      else $error("illegal source code");
   a_read_strobes: assert property (rxDataRead == (rdStrobe && addr == 3'h0)
      && lineStatusRead == (rdStrobe && addr == 3'h5))
      else $error("read strobe decode wrong");
endmodule
bind uart_intr_fifo_line_ctrl uart_ctrl_assertions u_chk (.*);

// *** core/irq_flag.sv ***
/*
 * one sticky interrupt flag: event sets, host
 * access clears.
 * assumes one-cycle set and clear on this clock.
 */
module irq_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag
);

   // ========================================================
   // set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag <= RST_VAL;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end

endmodule

// *** core/rx_timeout_timer.sv ***
/*
 * receive timeout counter in bit times.
 * assumes bitTick pulses once per bit time and
 * limit is the full count in bit times.
 */
module rx_timeout_timer (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       bitTick,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [5:0] limit,
   output logic            expire
);

   logic [5:0] count_r;   // bit times since last activity
   logic       done_r;    // fired once, wait for restart

   // ========================================================
   // count bit ticks while armed; fire one pulse on reaching limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= 6'h00;
         done_r  <= 1'b0;
         expire  <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (restart || !run) begin
            count_r <= 6'h00;
            done_r  <= 1'b0;
         end else if (bitTick && !done_r) begin
            if (count_r + 6'h01 >= limit) begin
               expire <= 1'b1;
               done_r <= 1'b1;
            end
            count_r <= count_r + 6'h01;
         end
      end
   end

endmodule

// *** core/uart_ctrl_defs.svh ***
/*
 * named constants of the uart control block:
 * offsets, fields, resets, interrupt codes,
 * trigger levels and timeout figures.
 * assumes inclusion by bare name from core files.
 */
`ifndef UART_CTRL_DEFS_SVH
`define UART_CTRL_DEFS_SVH

// ==========================================================
// register offsets on the 3-bit register port
`define OFS_DATA       3'h0
`define OFS_INTR_EN    3'h1
`define OFS_INTR_SRC   3'h2
`define OFS_LINE_FMT   3'h3
`define OFS_LINE_STAT  3'h5
`define OFS_MODEM_STAT 3'h6

// ==========================================================
// interrupt enable fields and reset value
`define IEN_RXDATA     0
`define IEN_TXEMPTY    1
`define IEN_LINE       2
`define IEN_MODEM      3
`define IEN_RST        4'h0

// ==========================================================
// fifo control fields
`define FCR_ENABLE     0
`define FCR_RXRESET    1
`define FCR_TXRESET    2
`define FCR_DMA        3
`define FCR_TRIG_LO    6
`define FCR_TRIG_HI    7

// ==========================================================
// line format fields and reset value
`define LFC_LEN_LO     0
`define LFC_LEN_HI     1
`define LFC_STOP       2
`define LFC_PAR_EN     3
`define LFC_EVEN       4
`define LFC_RST        8'h00

// ==========================================================
// interrupt source codes, lowest four bits of the source register
`define ID_LINE        4'h6
`define ID_TIMEOUT     4'hC
`define ID_RXDATA      4'h4
`define ID_TXREADY     4'h2
`define ID_MODEM       4'h0
`define ID_NONE        4'h1

// ==========================================================
// receive trigger levels in characters
`define TRIG_SEL0      5'h01
`define TRIG_SEL1      5'h04
`define TRIG_SEL2      5'h08
`define TRIG_SEL3      5'h0E

// ==========================================================
// receive timeout: four characters plus twelve bit times
`define TOUT_CHARS     6'h04
`define TOUT_BITS      6'h0C
`define FRAME_BASE     6'h06
`define STOP_EXTRA     6'h01

`endif

// *** core/uart_ctrl_pkg.sv ***
/*
 * types shared by the uart control block and bench.
 * assumes nothing beyond the compiler.
 */
package uart_ctrl_pkg;

   // ========================================================
   // configuration carried to the fifo and serializer logic
   typedef struct packed {
      logic [1:0] trigSel;     // receive trigger select
      logic       dmaMode;     // ready pin mode
      logic       enable;      // both fifos on
   } fifo_cfg_t;

   typedef struct packed {
      logic [1:0] wordLen;     // 0..3 means 5..8 bits
      logic       stopBits;    // long stop
      logic       parityEn;    // parity on
      logic       evenParity;  // even when set, odd when clear
   } line_cfg_t;

   // ========================================================
   // receive side status reported by the datapath
   typedef struct packed {
      logic [4:0] fill;        // characters in receive fifo
      logic       push;        // one cycle: character stored
   } rx_side_t;

endpackage

// *** core/uart_intr_fifo_line_ctrl.sv ***
/*
 * per-channel uart control: interrupt enable,
 * prioritised source id, fifo control and
 * line format control.
 * assumes fifos, serializers and status
 * registers sit outside on the same clock,
 * reporting events here and taking strobes.
 * reads answer one cycle after the strobe.
 */
// Implementation choices: the address-and-strobe port and the address map.
`include "uart_ctrl_defs.svh"

// Functional notes
// [RULE_01] source read returns highest pending interrupt only
// [RULE_02] one pending source reported, others wait
// [RULE_03] priority codes: 6, C, 4, 2, 0; none 1
// [RULE_04] bit 0 low while pending, high otherwise
// [RULE_05] line error raises; line status read clears
// [RULE_06] rx fill at trigger raises; below clears
// [RULE_07] four chars plus twelve bits timeout; data read clears
// [RULE_08] tx empty raises; source read or write clears
// [RULE_09] modem change raises; modem status read clears
// [RULE_10] bits 7:6 show fifo enable; 5:4 zero
// [RULE_11] fifo control write-only; bit 0 gates write
// [RULE_12] fifo control bit 1 resets rx fifo
// [RULE_13] fifo control bit 2 resets tx fifo
// [RULE_14] fifo control bit 3 selects dma pin mode
// [RULE_15] bits 7:6 pick trigger 1, 4, 8, 14
// [RULE_16] line bits 1:0 give 5 to 8 bits
// [RULE_17] line bit 2 gives longer stop bits
// [RULE_18] line bit 3 enables parity
// [RULE_19] each source reported only when enabled
// [RULE_20] enabling tx empty while empty raises interrupt
// [RULE_21] line bit 4 selects even over odd
// [RULE_22] interrupt output high while enabled source pending
module uart_intr_fifo_line_ctrl (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // register port
   input  wire logic [2:0]             addr,
   input  wire logic [7:0]             wrData,
   input  wire logic                   wrStrobe,
   input  wire logic                   rdStrobe,
   output logic      [7:0]             rdData,
   // datapath status
   input  wire uart_ctrl_pkg::rx_side_t rxSide,
   input  wire logic                   txFifoEmpty,
   input  wire logic                   txFifoFull,
   input  wire logic [3:0]             lineErr,
   input  wire logic [3:0]             modemDelta,
   input  wire logic                   bitTick,
   // strobes to the datapath
   output logic                        rxFifoReset,
   output logic                        txFifoReset,
   output logic                        rxDataRead,
   output logic                        txDataWrite,
   output logic                        lineStatusRead,
   output logic                        modemStatusRead,
   // configuration and pins
   output uart_ctrl_pkg::fifo_cfg_t    fifoCfg,
   output uart_ctrl_pkg::line_cfg_t    lineCfg,
   output logic                        intr,
   output logic                        receiveReadyPinN,
   output logic                        transmitReadyPinN
);
   import uart_ctrl_pkg::*;

   // ========================================================
   // declarations
   logic [3:0] intrEn_r;       // interrupt enable register
   logic [7:0] lineFmt_r;      // line format control register
   fifo_cfg_t  fifoCfg_r;      // fifo control, write-only
   logic [7:0] rdData_r;       // registered read answer
   logic [7:0] rdData_nxt;     // read answer for this cycle's strobe
   logic [3:0] lineErrPrev_r;  // last line error bits, for edges
   logic [3:0] modemPrev_r;    // last modem delta bits, for edges
   logic       txEmptyPrev_r;  // last tx empty level, for edges
   logic       rxFifoReset_r;  // one-cycle rx fifo reset pulse
   logic       txFifoReset_r;  // one-cycle tx fifo reset pulse

   logic       wrIntrEn;       // host writes interrupt enable
   logic       wrFifoCtl;      // host writes fifo control
   logic       wrLineFmt;      // host writes line format
   logic       rdIntrSrc;      // host reads source register

   logic       lineFlag;       // line status pending
   logic       toutFlag;       // receive timeout pending
   logic       txFlag;         // transmit ready pending
   logic       modemFlag;      // modem status pending
   logic       rxLevel;        // receive data at trigger
   logic       toutExpire;     // timer fired this cycle

   logic       lineSet;        // new line error seen
   logic       modemSet;       // new modem change seen
   logic       txSet;          // transmitter became ready
   logic       txClr;          // transmit ready serviced

   logic [4:0] trigLevel;      // decoded trigger in characters
   logic [5:0] frameBits;      // bits of one character frame
   logic [5:0] toutLimit;      // timeout in bit times
   logic       toutRun;        // timer armed
   logic [3:0] intrId;         // encoded highest source
   logic [7:0] intrSrc;        // full source register value

   // ========================================================
   // address decode; strobes never overlap
   assign wrIntrEn  = wrStrobe && (addr == `OFS_INTR_EN);
   assign wrFifoCtl = wrStrobe && (addr == `OFS_INTR_SRC);
   assign wrLineFmt = wrStrobe && (addr == `OFS_LINE_FMT);
   assign rdIntrSrc = rdStrobe && (addr == `OFS_INTR_SRC);

   // strobes for registers kept outside
   assign rxDataRead      = rdStrobe && (addr == `OFS_DATA);
   assign txDataWrite     = wrStrobe && (addr == `OFS_DATA);
   assign lineStatusRead  = rdStrobe && (addr == `OFS_LINE_STAT);
   assign modemStatusRead = rdStrobe && (addr == `OFS_MODEM_STAT);

   // ========================================================
   // interrupt enable register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         intrEn_r <= `IEN_RST;
      end else if (wrIntrEn) begin
         intrEn_r <= wrData[3:0];       // upper bits reserved
      end
   end

   // ========================================================
   // fifo control register: write-only, no read path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fifoCfg_r <= '0;
      end else if (wrFifoCtl) begin
         fifoCfg_r.enable <= wrData[`FCR_ENABLE];               // RULE_11
         // other fields take effect only with the enable bit set
         if (wrData[`FCR_ENABLE]) begin                         // RULE_11
            fifoCfg_r.dmaMode <= wrData[`FCR_DMA];              // RULE_14
            fifoCfg_r.trigSel <=
               wrData[`FCR_TRIG_HI:`FCR_TRIG_LO];               // RULE_15
         end
      end
   end

   // ========================================================
   // fifo reset pulses; the bits are never stored, so they
   // self-clear. shift registers are untouched: only the
   // pointer logic sees these pulses.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxFifoReset_r <= 1'b0;
         txFifoReset_r <= 1'b0;
      end else begin
         rxFifoReset_r <= wrFifoCtl && wrData[`FCR_ENABLE]
                          && wrData[`FCR_RXRESET];              // RULE_12
         txFifoReset_r <= wrFifoCtl && wrData[`FCR_ENABLE]
                          && wrData[`FCR_TXRESET];              // RULE_13
      end
   end

   assign rxFifoReset = rxFifoReset_r;
   assign txFifoReset = txFifoReset_r;
   assign fifoCfg     = fifoCfg_r;

   // ========================================================
   // line format register; all eight bits kept so
   // that unused bits still read back
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lineFmt_r <= `LFC_RST;
      end else if (wrLineFmt) begin
         lineFmt_r <= wrData;
      end
   end

   // fields handed to both serializers
   always_comb begin
      lineCfg.wordLen    = lineFmt_r[`LFC_LEN_HI:`LFC_LEN_LO];  // RULE_16
      lineCfg.stopBits   = lineFmt_r[`LFC_STOP];                // RULE_17
      lineCfg.parityEn   = lineFmt_r[`LFC_PAR_EN];              // RULE_18
      lineCfg.evenParity = lineFmt_r[`LFC_EVEN];                // RULE_21
   end

   // ========================================================
   // edge history for event detection
   // levels stay high until read, so only a rising
   // edge may set a flag; else a clearing read
   // would be undone at once
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lineErrPrev_r <= 4'h0;
         modemPrev_r   <= 4'h0;
         txEmptyPrev_r <= 1'b1;
      end else begin
         lineErrPrev_r <= lineErr;
         modemPrev_r   <= modemDelta;
         txEmptyPrev_r <= txFifoEmpty;
      end
   end

   // ========================================================
   // line status source
   assign lineSet = |(lineErr & ~lineErrPrev_r);                // RULE_05

   irq_flag #(
      .RST_VAL (1'b0)
   ) lineIrq (
      .clk  (clk),
      .rstn (rstn),
      .set  (lineSet),
      .clr  (lineStatusRead),                                   // RULE_05
      .flag (lineFlag)
   );

   // ========================================================
   // modem status source
   assign modemSet = |(modemDelta & ~modemPrev_r);              // RULE_09

   irq_flag #(
      .RST_VAL (1'b0)
   ) modemIrq (
      .clk  (clk),
      .rstn (rstn),
      .set  (modemSet),
      .clr  (modemStatusRead),                                  // RULE_09
      .flag (modemFlag)
   );

   // ========================================================
   // transmit ready source
   // raised on going empty, and on enabling while
   // already empty, so software sees a fresh request
   assign txSet = (txFifoEmpty && !txEmptyPrev_r)               // RULE_08
                  || (wrIntrEn && wrData[`IEN_TXEMPTY]
                      && !intrEn_r[`IEN_TXEMPTY]
                      && txFifoEmpty);                          // RULE_20
   // a source read clears it only when it was what was reported
   assign txClr = txDataWrite
                  || (rdIntrSrc && intrId == `ID_TXREADY);      // RULE_08

   irq_flag #(
      .RST_VAL (1'b0)
   ) txIrq (
      .clk  (clk),
      .rstn (rstn),
      .set  (txSet),
      .clr  (txClr),
      .flag (txFlag)
   );

   // ========================================================
   // receive data source: a level, not a flag, so
   // it drops once reads bring fill below trigger
   always_comb begin
      case (fifoCfg_r.trigSel)                                  // RULE_15
         2'b00:   trigLevel = `TRIG_SEL0;
         2'b01:   trigLevel = `TRIG_SEL1;
         2'b10:   trigLevel = `TRIG_SEL2;
         2'b11:   trigLevel = `TRIG_SEL3;
         default: trigLevel = `TRIG_SEL0;
      endcase
   end

   // without fifos a single held character is the trigger
   assign rxLevel = fifoCfg_r.enable ? (rxSide.fill >= trigLevel)
                                     : (rxSide.fill != 5'h00); // RULE_06

   // ========================================================
   // receive timeout source
   // frame = start + data + parity; no stop bit is
   // counted unless long stop is set, which adds one,
   // lengthening the timeout slightly
   assign frameBits = `FRAME_BASE + {4'h0, lineCfg.wordLen}
                      + {5'h00, lineCfg.parityEn}
                      + (lineCfg.stopBits ? `STOP_EXTRA : 6'h00);
   assign toutLimit = 6'((`TOUT_CHARS * frameBits)
                      + `TOUT_BITS);                            // RULE_07
   assign toutRun   = fifoCfg_r.enable && (rxSide.fill != 5'h00);

   rx_timeout_timer toutTimer (
      .clk     (clk),
      .rstn    (rstn),
      .bitTick (bitTick),
      .run     (toutRun),
      .restart (rxSide.push || rxDataRead),
      .limit   (toutLimit),
      .expire  (toutExpire)
   );

   irq_flag #(
      .RST_VAL (1'b0)
   ) toutIrq (
      .clk  (clk),
      .rstn (rstn),
      .set  (toutExpire),                                       // RULE_07
      .clr  (rxDataRead),                                       // RULE_07
      .flag (toutFlag)
   );

   // ========================================================
   // priority encoder: only the highest enabled
   // pending code shows; the rest wait
   always_comb begin
      if (lineFlag && intrEn_r[`IEN_LINE]) begin                // RULE_19
         intrId = `ID_LINE;                                     // RULE_03
      end else if (toutFlag && intrEn_r[`IEN_RXDATA]) begin
         intrId = `ID_TIMEOUT;                                  // RULE_03
      end else if (rxLevel && intrEn_r[`IEN_RXDATA]) begin
         intrId = `ID_RXDATA;                                   // RULE_03
      end else if (txFlag && intrEn_r[`IEN_TXEMPTY]) begin
         intrId = `ID_TXREADY;                                  // RULE_03
      end else if (modemFlag && intrEn_r[`IEN_MODEM]) begin
         intrId = `ID_MODEM;                                    // RULE_03
      end else begin
         intrId = `ID_NONE;                                     // RULE_04
      end
   end
   // RULE_01
   // RULE_02

   // fifo status mirrored twice, reserved bits zero
   assign intrSrc = {fifoCfg_r.enable, fifoCfg_r.enable,
                     2'b00, intrId};                            // RULE_10

   // ========================================================
   // interrupt output
   assign intr = (intrId != `ID_NONE);                          // RULE_22

   // ========================================================
   // ready pins, active low
   // normal: one character; dma: receive waits for
   // trigger or timeout, transmit for fifo room
   always_comb begin
      if (fifoCfg_r.dmaMode && fifoCfg_r.enable) begin          // RULE_14
         receiveReadyPinN  = !(rxLevel || toutFlag);
         transmitReadyPinN = txFifoFull;
      end else begin
         receiveReadyPinN  = (rxSide.fill == 5'h00);
         transmitReadyPinN = !txFifoEmpty;
      end
   end

   // ========================================================
   // read mux; datapath offsets answer zero here,
   // merged outside; fifo control is write-only,
   // its offset reads the source register
   always_comb begin
      rdData_nxt = 8'h00;
      case (addr)
         `OFS_INTR_EN:  rdData_nxt = {4'h0, intrEn_r};
         `OFS_INTR_SRC: rdData_nxt = intrSrc;                   // RULE_01
         `OFS_LINE_FMT: rdData_nxt = lineFmt_r;
         default:       rdData_nxt = 8'h00;
      endcase
   end

   // answer stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_r <= 8'h00;
      end else if (rdStrobe) begin
         rdData_r <= rdData_nxt;
      end else begin
         rdData_r <= 8'h00;
      end
   end

   assign rdData = rdData_r;

endmodule
